// ---- audio_port_pkg.sv ----
/*
  Shared constants for the two-port serial audio block.
  Assumes a single 20 MHz system clock; no software registers.
*/
package audio_port_pkg;
  localparam int WORD_BITS = 16;
  localparam int CLK_HZ = 20000000;
  localparam int FRAME_HZ = 48000;
  localparam int FRAME_BITS_SHORT = 32;
  localparam int FRAME_BITS_LONG = 50;
  localparam int SLAVE_MAX_BCLK_HZ = 3072000;
  // Divider defaults: N/M of the system clock gives twice the bit rate
  localparam logic [15:0] DIV_N_SHORT = 16'h0600;
  localparam logic [15:0] DIV_N_LONG = 16'h0960;
  localparam logic [15:0] DIV_M_DEFAULT = 16'h2710;
  localparam logic [5:0] HALF_BITS_SHORT = 6'h10;
  localparam logic [5:0] HALF_BITS_LONG = 6'h19;
  localparam int SYNC_STAGES = 3;
endpackage

// ---- audio_lane.sv ----
/*
  One serial audio port: clock generation or recovery, word select,
  16-bit transmit and receive shift registers.
  Assumes clkEn qualifies every state change and pin inputs are async.
*/
`timescale 1ns/1ps
`default_nettype none
module audio_lane (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic masterMode,
  input wire logic longFrame,
  input wire logic [15:0] divNum,
  input wire logic [15:0] divDen,
  input wire logic [15:0] txLeft,
  input wire logic [15:0] txRight,
  output logic txTake,
  output logic [15:0] rxLeft,
  output logic [15:0] rxRight,
  output logic rxValid,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic wsIn,
  output logic wsOut,
  output logic wsOe,
  output logic sdoOut,
  input wire logic sdiIn
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sckSync_r, wsSync_r, sdiSync_r;
  logic sckLvl_r, wsLvl_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      sckSync_r <= 3'h0;
      wsSync_r <= 3'h0;
      sdiSync_r <= 3'h0;
      sckLvl_r <= 1'b0;
      wsLvl_r <= 1'b0;
    end else if (clkEn) begin
      sckSync_r <= {sckSync_r[1:0], sckIn};
      wsSync_r <= {wsSync_r[1:0], wsIn};
      sdiSync_r <= {sdiSync_r[1:0], sdiIn};
      if (sckSync_r[1] == sckSync_r[2]) sckLvl_r <= sckSync_r[2];
      if (wsSync_r[1] == wsSync_r[2]) wsLvl_r <= wsSync_r[2];
    end
  end

  // ----------------------------------------
  // Master clock: fractional N/M accumulator toggles the bit clock
  // ----------------------------------------
  logic [16:0] acc_r;
  logic [16:0] accSum;
  logic phaseTick;
  logic mSck_r;
  assign accSum = acc_r + {1'b0, divNum};
  assign phaseTick = accSum >= {1'b0, divDen};
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r <= 17'h0;
      mSck_r <= 1'b0;
    end else if (clkEn && masterMode) begin
      // Every toggle is a whole number of clk periods apart, so the
      // ratio stays close to half at 1.5-2.4 MHz, above 0.35T
      acc_r <= phaseTick ? accSum - {1'b0, divDen} : accSum;
      if (phaseTick) mSck_r <= ~mSck_r;
    end
  end

  // ----------------------------------------
  // Edge events in either mode
  // ----------------------------------------
  logic sckPrev_r;
  logic sckNow, wsNow, fallEv, riseEv;
  // WS as taken at the last rise; both shifters key off it, so a slave
  // WS that moves with the falling pin edge is not taken one bit early
  logic rxWs_r;
  assign sckNow = masterMode ? mSck_r : sckLvl_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      sckPrev_r <= 1'b0;
    end else if (clkEn) begin
      sckPrev_r <= sckNow;
    end
  end
  assign fallEv = sckPrev_r & ~sckNow;
  assign riseEv = ~sckPrev_r & sckNow;

  // ----------------------------------------
  // Word select generation (master) at 48 kHz frame
  // ----------------------------------------
  logic [5:0] bitCnt_r, halfBits;
  logic mWs_r;
  assign halfBits = longFrame ? audio_port_pkg::HALF_BITS_LONG :
                    audio_port_pkg::HALF_BITS_SHORT;
  always_ff @(posedge clk) begin
    if (rst) begin
      bitCnt_r <= 6'h0;
      mWs_r <= 1'b0;
    end else if (clkEn && masterMode && fallEv) begin
      if (bitCnt_r == halfBits - 6'h1) begin
        bitCnt_r <= 6'h0;
        mWs_r <= ~mWs_r;
      end else begin
        bitCnt_r <= bitCnt_r + 6'h1;
      end
    end
  end
  assign wsNow = masterMode ? mWs_r : wsLvl_r;

  // ----------------------------------------
  // Transmit: shift on falling edge, MSB one clock after WS edge
  // ----------------------------------------
  logic [15:0] txShift_r;
  logic [4:0] txIdx_r;
  logic wsSeen_r, txArm_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      txShift_r <= 16'h0;
      txIdx_r <= 5'h0;
      sdoOut <= 1'b0;
      wsSeen_r <= 1'b0;
      txArm_r <= 1'b0;
    end else if (clkEn && fallEv) begin
      wsSeen_r <= rxWs_r;
      if (rxWs_r != wsSeen_r) begin
        // WS seen changed at the last rise: MSB goes out now
        txShift_r <= {(rxWs_r ? txRight[14:0] : txLeft[14:0]), 1'b0};
        sdoOut <= rxWs_r ? txRight[15] : txLeft[15];
        txIdx_r <= 5'h1;
        txArm_r <= 1'b1;
      end else if (txArm_r && txIdx_r < 5'h10) begin
        sdoOut <= txShift_r[15];
        txShift_r <= {txShift_r[14:0], 1'b0};
        txIdx_r <= txIdx_r + 5'h1;
      end else begin
        sdoOut <= 1'b0;
      end
    end
  end
  // Data are fetched on the left word start; right is read at its own word start
  assign txTake = clkEn & fallEv & (rxWs_r != wsSeen_r) & ~rxWs_r;

  // ----------------------------------------
  // Receive: sample on rising edge, drop bits past the LSB
  // ----------------------------------------
  logic [15:0] rxShift_r;
  logic [4:0] rxIdx_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      rxShift_r <= 16'h0;
      rxIdx_r <= 5'h10;
      rxWs_r <= 1'b0;
      rxLeft <= 16'h0;
      rxRight <= 16'h0;
      rxValid <= 1'b0;
    end else if (clkEn) begin
      rxValid <= 1'b0;
      if (riseEv) begin
        rxWs_r <= wsNow;
        // With 16-bit halves the LSB rides the rise that sees WS change,
        // so that bit still belongs to the old channel
        if (rxIdx_r < 5'h10) begin
          rxShift_r <= {rxShift_r[14:0], sdiSync_r[2]};
          if (rxIdx_r == 5'hf) begin
            if (rxWs_r) begin
              rxRight <= {rxShift_r[14:0], sdiSync_r[2]};
              rxValid <= 1'b1;
            end else begin
              rxLeft <= {rxShift_r[14:0], sdiSync_r[2]};
            end
          end
        end // extra bits ignored
        if (wsNow != rxWs_r) begin
          rxIdx_r <= 5'h0; // first bit comes next rising edge
        end else if (rxIdx_r < 5'h10) begin
          rxIdx_r <= rxIdx_r + 5'h1;
        end
      end
    end
  end

  assign sckOut = mSck_r;
  assign sckOe = masterMode;
  assign wsOut = mWs_r;
  assign wsOe = masterMode;
endmodule
`default_nettype wire

// ---- audio_port_top.sv ----
/*
  Top of the dual serial audio port block.
  Assumes static configuration inputs and the pad ring resolving enables.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Two independent ports, each set to master or slave on its own.
// - Master drives clock and word select, slave takes them; data always out.
// - Words are 16 bits, MSB first, left MSB one bit clock after the frame start.
// - MSB comes one bit clock after a WS edge; bits change on falling edges.
// - Left words travel while WS is low, right words while WS is high.
// - Master makes 48 kHz frames of 32 or 50 bit clocks.
// - Master bit clock comes from the reference clock through an N/M divider.
// - Master bit clock keeps a ratio close to half, each phase at least 0.35 period.
module audio_port_top #(
  parameter int PORTS = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [PORTS-1:0] masterMode,
  input wire logic [PORTS-1:0] longFrame,
  input wire logic [PORTS*16-1:0] divNum,
  input wire logic [PORTS*16-1:0] divDen,
  input wire logic [PORTS*16-1:0] txLeft,
  input wire logic [PORTS*16-1:0] txRight,
  output logic [PORTS-1:0] txTake,
  output logic [PORTS*16-1:0] rxLeft,
  output logic [PORTS*16-1:0] rxRight,
  output logic [PORTS-1:0] rxValid,
  input wire logic [PORTS-1:0] sckIn,
  output logic [PORTS-1:0] sckOut,
  output logic [PORTS-1:0] sckOe,
  input wire logic [PORTS-1:0] wsIn,
  output logic [PORTS-1:0] wsOut,
  output logic [PORTS-1:0] wsOe,
  output logic [PORTS-1:0] sdoOut,
  input wire logic [PORTS-1:0] sdiIn
);
  // ----------------------------------------
  // Independent port instances
  // ----------------------------------------
  // Slave rate up to 3.072 MHz gives >3 clk per phase at 20 MHz, enough
  // for the 3-stage synchroniser to see every edge
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    audio_lane u_lane (
      .clk(clk),
      .rst(rst),
      .clkEn(clkEn),
      .masterMode(masterMode[p]),
      .longFrame(longFrame[p]),
      .divNum(divNum[p*16 +: 16]),
      .divDen(divDen[p*16 +: 16]),
      .txLeft(txLeft[p*16 +: 16]),
      .txRight(txRight[p*16 +: 16]),
      .txTake(txTake[p]),
      .rxLeft(rxLeft[p*16 +: 16]),
      .rxRight(rxRight[p*16 +: 16]),
      .rxValid(rxValid[p]),
      .sckIn(sckIn[p]),
      .sckOut(sckOut[p]),
      .sckOe(sckOe[p]),
      .wsIn(wsIn[p]),
      .wsOut(wsOut[p]),
      .wsOe(wsOe[p]),
      .sdoOut(sdoOut[p]),
      .sdiIn(sdiIn[p])
    );
  end
endmodule
`default_nettype wire

// ---- audio_port_checker.sv ----
/* Checker for the audio port top; port 0 is watched as master.
   Assumes it is bound into the top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module audio_port_checker #(
  parameter int PORTS = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [PORTS-1:0] masterMode,
  input wire logic [PORTS-1:0] longFrame,
  input wire logic [PORTS-1:0] txTake,
  input wire logic [PORTS-1:0] rxValid,
  input wire logic [PORTS-1:0] sckOut,
  input wire logic [PORTS-1:0] sckOe,
  input wire logic [PORTS-1:0] wsOut,
  input wire logic [PORTS-1:0] wsOe,
  input wire logic [PORTS-1:0] sdoOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic mst;
  logic [5:0] bits_r;
  logic armed_r;
  assign mst = masterMode[0];
  // Bit clocks since the last select edge; the first edge only arms
  always_ff @(posedge clk) begin
    if (rst || $changed(wsOut[0])) bits_r <= 6'h00;
    else if ($rose(sckOut[0])) bits_r <= bits_r + 6'h01;
  end
  always_ff @(posedge clk) begin
    if (rst) armed_r <= 1'b0;
    else if ($changed(wsOut[0])) armed_r <= 1'b1;
  end
  property p_oe; sckOe == masterMode && wsOe == masterMode; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_sdo; mst && $changed(sdoOut[0]) |-> !sckOut[0]; endproperty
  a_sdo: assert property (p_sdo) else $error("sdo edge");
  property p_hi; mst && $rose(sckOut[0]) |-> sckOut[0][*3]; endproperty
  a_hi: assert property (p_hi) else $error("high short");
  property p_lo; mst && $fell(sckOut[0]) |-> (!sckOut[0])[*3]; endproperty
  a_lo: assert property (p_lo) else $error("low short");
  property p_half;
    mst && armed_r && $changed(wsOut[0]) |->
      bits_r == (longFrame[0] ? 6'h19 : 6'h10);
  endproperty
  a_half: assert property (p_half) else $error("half len");
  property p_take; mst && txTake[0] |-> !wsOut[0]; endproperty
  a_take: assert property (p_take) else $error("take ws");
  property p_vld; rxValid[0] |=> !rxValid[0]; endproperty
  a_vld: assert property (p_vld) else $error("valid long");
  property p_tail; mst && armed_r && bits_r > 6'h11 |-> !sdoOut[0];
  endproperty
  a_tail: assert property (p_tail) else $error("tail");
  c_m: cover property (mst && txTake[0]);
  c_l: cover property (longFrame[0] && rxValid[0]);
  c_s: cover property (!masterMode[1] && rxValid[1]);
endmodule
bind audio_port_top audio_port_checker #(.PORTS(PORTS)) chk (.clk(clk),
  .rst(rst), .masterMode(masterMode), .longFrame(longFrame),
  .txTake(txTake), .rxValid(rxValid), .sckOut(sckOut), .sckOe(sckOe),
  .wsOut(wsOut), .wsOe(wsOe), .sdoOut(sdoOut));
`default_nettype wire

// ---- audio_codec_model.sv ----
/* Far-side codec master: makes bit clock and select, sends two words.
   Assumes the port facing it is in slave mode while run is high. */
`timescale 1ns/1ps
`default_nettype none
module audio_codec_model #(
  parameter logic [15:0] LEFT = 16'h9b17,
  parameter logic [15:0] RIGHT = 16'h64e8
) (
  input wire logic run,
  input wire logic sdo,
  output logic sck,
  output logic ws,
  output logic sdi,
  output logic [15:0] capL,
  output logic [15:0] capR
);
  // 800 ns bit: under the slave limit, port sync lag fits a half period
  logic [15:0] word;
  logic [15:0] shift;
  initial begin
    {sck, ws, sdi, capL, capR, shift} = '0;
    forever begin
      wait (run);
      for (int h = 0; h < 2; h++) begin
        word = h ? RIGHT : LEFT;
        for (int i = 0; i < 20; i++) begin
          #400 sck = 1'b0;
          if (i == 0) ws = h[0];
          // Past the LSB the line toggles junk the port must ignore
          sdi = (i > 0 && i < 17) ? word[16 - i] : ~sdi;
          #400 sck = 1'b1;
          if (i > 0 && i < 17) shift = {shift[14:0], sdo};
        end
        if (h) capR = shift;
        else capL = shift;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
/* Port 0 master looped onto itself, port 1 slave to the codec model.
   Assumes configuration changes only while reset is held. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst, run, prv, en;
  logic [1:0] lf, take, vld, sckI, sckO, sckE, wsI, wsO, wsE, sdo, sdi;
  logic [31:0] divN, rxL, rxR;
  logic mSck, mWs, mSdi;
  logic [15:0] capL, capR;
  int err_count = 0;
  int num_checks = 0;
  localparam logic [31:0] TXL = 32'h7ffe8001;
  localparam logic [31:0] TXR = 32'h3c5aa5c3;
  localparam int FRAME_CYC = audio_port_pkg::CLK_HZ / audio_port_pkg::FRAME_HZ;
  assign sckI = {sckE[1] ? sckO[1] : mSck, sckO[0]};
  assign wsI = {wsE[1] ? wsO[1] : mWs, wsO[0]};
  assign sdi = {mSdi, sdo[0]};
  audio_port_top dut (.clk(clk), .rst(rst), .clkEn(en),
    .masterMode(2'h1), .longFrame(lf), .divNum(divN),
    .divDen({2{audio_port_pkg::DIV_M_DEFAULT}}), .txLeft(TXL),
    .txRight(TXR), .txTake(take), .rxLeft(rxL), .rxRight(rxR),
    .rxValid(vld), .sckIn(sckI), .sckOut(sckO), .sckOe(sckE),
    .wsIn(wsI), .wsOut(wsO), .wsOe(wsE), .sdoOut(sdo), .sdiIn(sdi));
  audio_codec_model codec (.run(run), .sdo(sdo[1]), .sck(mSck),
    .ws(mWs), .sdi(mSdi), .capL(capL), .capR(capR));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2000000;
    err_count++;
    end_of_test();
  end
  task automatic check(input logic [15:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_vld(input int p);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (vld[p] !== 1'b1 && k < 3000);
    check(16'(k < 3000), 16'h0001, "valid wait");
  endtask
  task automatic t_master(input logic lng);
    int cyc, rises;
    logic inFrame;
    lf[0] = lng;
    divN[15:0] = lng ? audio_port_pkg::DIV_N_LONG
                     : audio_port_pkg::DIV_N_SHORT;
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    wait_vld(0);
    wait_vld(0);
    check(rxL[15:0], TXL[15:0], "loop left");
    check(rxR[15:0], TXR[15:0], "loop right");
    cyc = 0;
    while (take[0] !== 1'b1 && cyc < 3000) begin
      @(negedge clk);
      cyc++;
    end
    cyc = 0;
    rises = 0;
    prv = sckO[0];
    do begin
      @(negedge clk);
      cyc++;
      rises += int'(sckO[0] && !prv);
      prv = sckO[0];
    end while (take[0] !== 1'b1 && cyc < 3000);
    check(16'(rises), lng ? 16'h0032 : 16'h0020, "bits");
    inFrame = cyc >= FRAME_CYC && cyc <= FRAME_CYC + 1;
    check(16'(inFrame), 16'h0001, "frame");
  endtask
  task automatic t_freeze();
    logic [2:0] held;
    en = 1'b0;
    @(negedge clk);
    held = {sckO[0], wsO[0], sdo[0]};
    repeat (40) @(negedge clk);
    check(16'({sckO[0], wsO[0], sdo[0]}), 16'(held), "freeze");
    en = 1'b1;
  endtask
  task automatic t_slave();
    run = 1'b1;
    wait_vld(1);
    wait_vld(1);
    wait_vld(1);
    run = 1'b0;
    check(rxL[31:16], 16'h9b17, "slave left");
    check(rxR[31:16], 16'h64e8, "slave right");
    check(capL, TXL[31:16], "codec left");
    check(capR, TXR[31:16], "codec right");
  endtask
  initial begin
    rst = 1'b1;
    run = 1'b0;
    en = 1'b1;
    lf = 2'h0;
    divN = {2{audio_port_pkg::DIV_N_SHORT}};
    t_master(1'b0);
    t_freeze();
    t_slave();
    t_master(1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
